// ### include/lsq_pkg.sv
// lsq_pkg: constants, states and timing for the display supply control.
// Assumes one 250 MHz pclk and an APB slave with 32-bit data.
// What this block does
// - Input valid above upper, invalid below lower
// - Lockout disables reference, outputs, releases switch
// - Precharge storage rail with limited rectifier
// - Start at reduced limit, ramp to full
// - Both switches on; limit turns one off
// - Restart at once or skip pulses
// - Inductor shared among three targets
// - Persistent output fault latches shutdown
// - Run high: switch on, converter starts
// - Enable powers source; gate-low after source good
// - Gate-high waits for gate-low good
// - Run low: gate rails off first
// - Discharge gate-high only during power-down
// - Feedback threshold: source off, then logic
// - Pin mode: start needs run and lockout release
// - Any fault disables all three together
// - Source low after fault: pin high, shutdown
// - Latch clears by run/enable low or lockout
`default_nettype none
package lsq_pkg;
	localparam int CLK_MHZ = 250;
	localparam int FAULT_TIME_US = 100;
	localparam int FAULT_CYC = FAULT_TIME_US * CLK_MHZ;
	localparam int SS_STEP_NS = 200;
	localparam int SS_STEP_CYC = (SS_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] ILIM_START_MA = 8'h41;
	localparam logic [7:0] ILIM_FULL_MA = 8'h96;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [1:0] CTRL_RST = 2'h3;
	localparam int CTRL_SKIP = 0;
	localparam int CTRL_START = 1;
	localparam int SYNC_W = 20;
	typedef enum logic [2:0] {
		SQ_OFF = 3'b000,
		SQ_PRECH = 3'b001,
		SQ_RUN = 3'b010,
		SQ_PDOWN = 3'b011,
		SQ_PDLOG = 3'b100,
		SQ_FLTDN = 3'b101,
		SQ_LATCH = 3'b110
	} lsq_seq_e;
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_CHARGE = 2'b01,
		SW_DUMP = 2'b10
	} lsq_sw_e;
	typedef enum logic [1:0] {
		TG_BOOT = 2'b00,
		TG_GH = 2'b01,
		TG_GL = 2'b10
	} lsq_tgt_e;
endpackage
`default_nettype wire

// ### hw/lsq_sync.sv
// lsq_sync: three-flop synchronizer for a vector of asynchronous inputs.
// Assumes inputs may change at any time relative to pclk.
`timescale 1ns/1ps
`default_nettype none
module lsq_sync #(
	parameter int W = 1
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// Change counts only once stages two and three agree
			for (int i = 0; i < W; i++)
			begin
				if (s2_reg[i] == s3_reg[i])
					sync_out[i] <= s3_reg[i];
			end
		end
	end
endmodule // lsq_sync
`default_nettype wire

// ### hw/lsq_tick.sv
// lsq_tick: enable-pulse divider, one pulse every DIV cycles while enabled.
// Assumes en held steady for the whole interval it is meant to measure.
`timescale 1ns/1ps
`default_nettype none
module lsq_tick #(
	parameter int DIV = 50
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	output logic tick
);
	localparam int CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end
		else if (!en)
		begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (cnt_reg == CW'(DIV - 1));
			cnt_reg <= (cnt_reg == CW'(DIV - 1)) ? '0 : cnt_reg + 1'b1;
		end
	end
endmodule // lsq_tick
`default_nettype wire

// ### hw/lsq_supply_ctrl.sv
// lsq_supply_ctrl: lockout, soft start, inductor multiplexing,
// output ordering and latched fault shutdown, with an APB slave.
// Assumes comparator results arrive asynchronously as logic levels.
`timescale 1ns/1ps
`default_nettype none
module lsq_supply_ctrl #(
	parameter bit AUTO_SEQ = 1'b1,
	parameter int FAULT_CYCLES = lsq_pkg::FAULT_CYC,
	parameter int SS_CYCLES = lsq_pkg::SS_STEP_CYC
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic run_pin,
	input wire logic en_pin,
	input wire logic gate_low_enable_pin,
	input wire logic gate_high_enable_pin,
	input wire logic vin_above_rise,
	input wire logic vin_above_fall,
	input wire logic precharge_done,
	input wire logic source_good,
	input wire logic gate_low_good,
	input wire logic source_fault,
	input wire logic gate_high_fault,
	input wire logic gate_low_fault,
	input wire logic negative_feedback_level_thr,
	input wire logic source_low,
	input wire logic inductor_at_limit,
	input wire logic inductor_empty,
	input wire logic req_boot,
	input wire logic req_gate_high,
	input wire logic req_gate_low,
	input wire logic logic_switch_in,
	output logic logic_switch_out,
	output logic logic_switch_oe_n,
	output logic reference_en,
	output logic boot_en,
	output logic source_drive_supply_en,
	output logic gate_low_supply_en,
	output logic gate_high_supply_en,
	output logic gate_high_discharge,
	output logic panel_digital_supply_en,
	output logic rectifier_limit,
	output logic high_side_switch_on,
	output logic low_side_switch_on,
	output logic [7:0] inductor_current_limit
);
	import lsq_pkg::*;
	localparam int FW = $clog2(FAULT_CYCLES + 1);
	logic [SYNC_W-1:0] sync_vec;
	logic run_s, en_s, glp_s, ghp_s, rise_s, fall_s, prech_s, sgood_s, glgood_s;
	logic sflt_s, ghflt_s, glflt_s, fbl_s, slow_s, atlim_s, empty_s;
	logic rqb_s, rqh_s, rql_s, swin_s;
	lsq_seq_e st_reg;
	lsq_sw_e sw_reg;
	lsq_tgt_e tgt_reg;
	lsq_tgt_e pick_tgt;
	logic input_undervoltage_lockout_ok_reg;
	logic bypass_reg;
	logic [1:0] ctrl_reg;
	logic [FW-1:0] fcnt_reg;
	logic flt_any, fault_trip, conv_on, any_rq, want_cycle, ss_tick, switch_on;
	lsq_sync #(.W(SYNC_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({run_pin, en_pin, gate_low_enable_pin, gate_high_enable_pin,
			vin_above_rise, vin_above_fall, precharge_done, source_good,
			gate_low_good, source_fault, gate_high_fault, gate_low_fault,
			negative_feedback_level_thr, source_low, inductor_at_limit,
			inductor_empty, req_boot, req_gate_high, req_gate_low, logic_switch_in}),
		.sync_out(sync_vec)
	);
	assign {run_s, en_s, glp_s, ghp_s, rise_s, fall_s, prech_s, sgood_s, glgood_s,
		sflt_s, ghflt_s, glflt_s, fbl_s, slow_s, atlim_s, empty_s,
		rqb_s, rqh_s, rql_s, swin_s} = sync_vec;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			input_undervoltage_lockout_ok_reg <= 1'b0;
		else if (rise_s)
			input_undervoltage_lockout_ok_reg <= 1'b1;
		else if (!fall_s)
			input_undervoltage_lockout_ok_reg <= 1'b0;
	end
	assign flt_any = (source_drive_supply_en & sflt_s) | (gate_high_supply_en & ghflt_s)
		| (gate_low_supply_en & glflt_s);
	// Fault must persist a full timer period
	assign fault_trip = (st_reg == SQ_RUN) && flt_any && (fcnt_reg == FW'(FAULT_CYCLES - 1));
	assign conv_on = (st_reg == SQ_RUN) || (st_reg == SQ_PDOWN);
	assign any_rq = rqb_s | (rqh_s & gate_high_supply_en) | (rql_s & gate_low_supply_en);
	// Continuous mode forces cycles when skipping is off
	assign want_cycle = conv_on && (any_rq || !ctrl_reg[CTRL_SKIP]);
	// Gate-low first, then gate-high, else storage rail
	assign pick_tgt = (rql_s && gate_low_supply_en) ? TG_GL :
		((rqh_s && gate_high_supply_en) ? TG_GH : TG_BOOT);
	assign switch_on = (st_reg == SQ_PRECH) || conv_on || (st_reg == SQ_PDLOG)
		|| (st_reg == SQ_FLTDN);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fcnt_reg <= '0;
		else if (st_reg != SQ_RUN || !flt_any)
			fcnt_reg <= '0;
		else if (fcnt_reg != FW'(FAULT_CYCLES - 1))
			fcnt_reg <= fcnt_reg + 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= SQ_OFF;
		else if (!input_undervoltage_lockout_ok_reg)
			st_reg <= SQ_OFF;
		else
		begin
			unique case (st_reg)
				SQ_OFF:
					// Run high starts; lockout already released
					if (run_s && ctrl_reg[CTRL_START])
						st_reg <= SQ_PRECH;
				SQ_PRECH:
					if (!run_s)
						st_reg <= SQ_OFF;
					else if (prech_s)
						st_reg <= SQ_RUN;
				SQ_RUN:
					if (fault_trip)
						st_reg <= SQ_FLTDN;
					else if (!run_s)
						st_reg <= bypass_reg ? SQ_OFF : SQ_PDOWN;
				SQ_PDOWN:
					if (fbl_s)
						st_reg <= SQ_PDLOG;
				SQ_PDLOG:
					st_reg <= SQ_OFF;
				SQ_FLTDN:
					// Shut down once source has fallen
					if (slow_s)
						st_reg <= SQ_LATCH;
				SQ_LATCH:
					// Both run and enable low release the latch
					if (!run_s && !en_s)
						st_reg <= SQ_OFF;
				default:
					st_reg <= SQ_OFF;
			endcase
		end
	end
	// Switch pin is only sensed while released
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bypass_reg <= 1'b0;
		else if (st_reg == SQ_OFF && !run_s)
			bypass_reg <= swin_s;
	end
	// Source follows enable, rails in order
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			source_drive_supply_en <= 1'b0;
			gate_low_supply_en <= 1'b0;
			gate_high_supply_en <= 1'b0;
		end
		// All three off together on a fault
		else if (st_reg != SQ_RUN || fault_trip || !run_s || !input_undervoltage_lockout_ok_reg)
		begin
			// Source held through power-down until threshold
			source_drive_supply_en <= input_undervoltage_lockout_ok_reg && source_drive_supply_en && !fbl_s
				&& (st_reg == SQ_PDOWN || (st_reg == SQ_RUN && !fault_trip && !bypass_reg));
			gate_low_supply_en <= 1'b0;
			gate_high_supply_en <= 1'b0;
		end
		else if (AUTO_SEQ)
		begin
			source_drive_supply_en <= en_s;
			gate_low_supply_en <= en_s && source_drive_supply_en
				&& (gate_low_supply_en || sgood_s);
			gate_high_supply_en <= en_s && gate_low_supply_en
				&& (gate_high_supply_en || glgood_s);
		end
		else
		begin
			// Each rail follows its own pin; system orders them
			source_drive_supply_en <= en_s;
			gate_low_supply_en <= glp_s;
			gate_high_supply_en <= ghp_s;
		end
	end
	// Logic switch, reference and converter controls
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			logic_switch_out <= 1'b0;
			logic_switch_oe_n <= 1'b1;
			panel_digital_supply_en <= 1'b0;
			reference_en <= 1'b0;
			boot_en <= 1'b0;
			rectifier_limit <= 1'b0;
			gate_high_discharge <= 1'b0;
		end
		else
		begin
			// Lockout releases the switch and stops everything
			reference_en <= input_undervoltage_lockout_ok_reg && (AUTO_SEQ || run_s || st_reg != SQ_OFF);
			boot_en <= input_undervoltage_lockout_ok_reg && conv_on;
			rectifier_limit <= input_undervoltage_lockout_ok_reg && (st_reg == SQ_PRECH);
			gate_high_discharge <= input_undervoltage_lockout_ok_reg && (st_reg == SQ_PDOWN);
			// Latched shutdown drives the switch pin high
			logic_switch_out <= input_undervoltage_lockout_ok_reg && (st_reg == SQ_LATCH);
			logic_switch_oe_n <= !(input_undervoltage_lockout_ok_reg && (st_reg == SQ_LATCH
				|| (switch_on && !bypass_reg)));
			panel_digital_supply_en <= input_undervoltage_lockout_ok_reg && switch_on && !bypass_reg;
		end
	end
	// Soft-start ramp of the current limit
	lsq_tick #(.DIV(SS_CYCLES)) u_ss_tick (
		.pclk(pclk),
		.presetn(presetn),
		.en(conv_on),
		.tick(ss_tick)
	);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			inductor_current_limit <= ILIM_START_MA;
		else if (!conv_on)
			inductor_current_limit <= ILIM_START_MA;
		else if (ss_tick && inductor_current_limit != ILIM_FULL_MA)
			inductor_current_limit <= inductor_current_limit + 8'h01;
	end
	// Switching cycle controller
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sw_reg <= SW_IDLE;
			tgt_reg <= TG_BOOT;
			high_side_switch_on <= 1'b0;
			low_side_switch_on <= 1'b0;
		end
		else if (!conv_on || !input_undervoltage_lockout_ok_reg)
		begin
			sw_reg <= SW_IDLE;
			high_side_switch_on <= 1'b0;
			low_side_switch_on <= 1'b0;
		end
		else
		begin
			unique case (sw_reg)
				SW_IDLE:
					// A cycle opens with both switches on
					if (want_cycle)
					begin
						sw_reg <= SW_CHARGE;
						tgt_reg <= pick_tgt;
						high_side_switch_on <= 1'b1;
						low_side_switch_on <= 1'b1;
					end
				SW_CHARGE:
					// At the limit, drop the switch for the target
					if (atlim_s)
					begin
						sw_reg <= SW_DUMP;
						if (tgt_reg == TG_GL)
							high_side_switch_on <= 1'b0;
						else
							low_side_switch_on <= 1'b0;
					end
				SW_DUMP:
					if (empty_s)
					begin
						sw_reg <= want_cycle ? SW_CHARGE : SW_IDLE;
						tgt_reg <= pick_tgt;
						high_side_switch_on <= want_cycle;
						low_side_switch_on <= want_cycle;
					end
				default:
					sw_reg <= SW_IDLE;
			endcase
		end
	end
	// APB slave, one wait-free access phase after the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pready <= 1'b1;
			pslverr <= (paddr != OFS_CTRL) && (paddr != OFS_STATUS);
			if (pwrite || paddr != OFS_CTRL && paddr != OFS_STATUS)
				prdata <= 32'h0000_0000;
			else if (paddr == OFS_CTRL)
				prdata <= {30'h0000_0000, ctrl_reg};
			else
				prdata <= {16'h0000, inductor_current_limit, bypass_reg, st_reg,
					gate_high_supply_en, gate_low_supply_en, source_drive_supply_en,
					input_undervoltage_lockout_ok_reg};
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_reg <= CTRL_RST;
		else if (psel && penable && pready && pwrite && paddr == OFS_CTRL)
			ctrl_reg <= pwdata[1:0];
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_input_undervoltage_lockout_rise: assert property ($rose(input_undervoltage_lockout_ok_reg) |-> $past(rise_s))
		else $error("lockout released without rising threshold");
	chk_input_undervoltage_lockout_off: assert property (!input_undervoltage_lockout_ok_reg |=> st_reg == SQ_OFF ##1
		!boot_en && !source_drive_supply_en && !gate_high_supply_en)
		else $error("outputs alive under lockout");
	chk_prech_lim: assert property (st_reg == SQ_PRECH && input_undervoltage_lockout_ok_reg |=>
		rectifier_limit && !high_side_switch_on)
		else $error("precharge without limited rectifier");
	chk_ss_start: assert property ($rose(conv_on) |=>
		inductor_current_limit == ILIM_START_MA)
		else $error("soft start not at reduced limit");
	chk_dump_switch: assert property (sw_reg == SW_DUMP |->
		((tgt_reg == TG_GL) ? (!high_side_switch_on && low_side_switch_on)
		: (high_side_switch_on && !low_side_switch_on)))
		else $error("wrong switch released for target");
	chk_skip_idle: assert property (sw_reg == SW_DUMP && empty_s && conv_on
		&& input_undervoltage_lockout_ok_reg && !any_rq && ctrl_reg[CTRL_SKIP] |=> sw_reg == SW_IDLE)
		else $error("pulse not skipped at light load");
	chk_fault_time: assert property ($rose(st_reg == SQ_FLTDN) |->
		$past(fcnt_reg) == FW'(FAULT_CYCLES - 1))
		else $error("fault latched before timer expired");
	chk_fault_all: assert property (fault_trip && input_undervoltage_lockout_ok_reg |=>
		!source_drive_supply_en && !gate_low_supply_en && !gate_high_supply_en)
		else $error("fault left a rail enabled");
	chk_gl_order: assert property (AUTO_SEQ && $rose(gate_low_supply_en) |->
		$past(source_drive_supply_en && sgood_s))
		else $error("gate-low before source good");
	chk_gh_order: assert property (AUTO_SEQ && $rose(gate_high_supply_en) |->
		$past(gate_low_supply_en && glgood_s))
		else $error("gate-high before gate-low good");
	chk_latch_pin: assert property ($rose(st_reg == SQ_LATCH) && input_undervoltage_lockout_ok_reg |=>
		logic_switch_out && !logic_switch_oe_n && !panel_digital_supply_en)
		else $error("latched shutdown not driving pin high");
endmodule // lsq_supply_ctrl
`default_nettype wire

// ### bench/lsq_sys_model.sv
// lsq_sys_model: system controller driving run, enable and rail enables.
// Assumes pclk domain; the released switch pin reads low through its pull-down.
`timescale 1ns/1ps
`default_nettype none
module lsq_sys_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic want_run,
	input wire logic want_en,
	input wire logic want_gates,
	input wire logic slow,
	input wire logic tie,
	input wire logic logic_switch_out,
	input wire logic logic_switch_oe_n,
	output logic run_pin,
	output logic en_pin,
	output logic gate_low_enable_pin,
	output logic gate_high_enable_pin,
	output logic logic_switch_in
);
	logic en_reg;
	logic gates_reg;
	logic [3:0] gap_reg;
	// run and enable tied, pin held high
	assign en_pin = tie ? run_pin : en_reg;
	assign logic_switch_in = tie | (!logic_switch_oe_n & logic_switch_out);
	assign gate_low_enable_pin = gates_reg;
	assign gate_high_enable_pin = gates_reg;
	// source enable brackets the gate enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_pin <= 1'b0;
			en_reg <= 1'b0;
			gates_reg <= 1'b0;
			gap_reg <= 4'h0;
		end
		else
		begin
			run_pin <= want_run;
			if (gap_reg != 4'h0)
				gap_reg <= gap_reg - 4'h1;
			else if (gates_reg != (want_gates & want_en & en_reg))
			begin
				gates_reg <= want_gates & want_en & en_reg;
				gap_reg <= slow ? 4'hc : 4'h1;
			end
			else if (!gates_reg && en_reg != want_en)
			begin
				en_reg <= want_en;
				gap_reg <= slow ? 4'hc : 4'h1;
			end
		end
	end
endmodule // lsq_sys_model
`default_nettype wire

// ### bench/lsq_supply_ctrl_test.sv
// lsq_supply_ctrl_test: self-checking bench for the supply sequencer.
// Assumes short fault and soft-start counts set by parameter.
`timescale 1ns/1ps
`default_nettype none
module lsq_supply_ctrl_test;
	localparam int K_OE = 0, K_OUT = 1, K_REF = 2, K_BOOT = 3, K_SRC = 4, K_GL = 5;
	localparam int K_GH = 6, K_PAN = 8, K_HS = 10, K_LS = 11, K_BOTH = 12;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic want_run, want_en, want_gates, slow, tie, run_pin, en_pin, logic_switch_in;
	logic gate_low_enable_pin, gate_high_enable_pin, vin_above_rise, vin_above_fall;
	logic precharge_done, source_good, gate_low_good, source_fault, gate_high_fault;
	logic gate_low_fault, negative_feedback_level_thr, source_low, inductor_at_limit;
	logic inductor_empty, req_boot, req_gate_high, req_gate_low, logic_switch_out;
	logic logic_switch_oe_n, reference_en, boot_en, source_drive_supply_en;
	logic gate_low_supply_en, gate_high_supply_en, gate_high_discharge;
	logic panel_digital_supply_en, rectifier_limit, high_side_switch_on, low_side_switch_on;
	logic [7:0] inductor_current_limit;
	logic [12:0] obs;
	int miscompares = 0, tests_run = 0, cyc = 0, n;
	assign obs = {high_side_switch_on & low_side_switch_on, low_side_switch_on,
		high_side_switch_on, rectifier_limit, panel_digital_supply_en, gate_high_discharge,
		gate_high_supply_en, gate_low_supply_en, source_drive_supply_en, boot_en,
		reference_en, logic_switch_out, logic_switch_oe_n};
	lsq_supply_ctrl #(.AUTO_SEQ(1'b1), .FAULT_CYCLES(20), .SS_CYCLES(2)) uut (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_pin,
		.en_pin, .gate_low_enable_pin, .gate_high_enable_pin, .vin_above_rise,
		.vin_above_fall, .precharge_done, .source_good, .gate_low_good, .source_fault,
		.gate_high_fault, .gate_low_fault, .negative_feedback_level_thr, .source_low,
		.inductor_at_limit, .inductor_empty, .req_boot, .req_gate_high, .req_gate_low,
		.logic_switch_in, .logic_switch_out, .logic_switch_oe_n, .reference_en, .boot_en,
		.source_drive_supply_en, .gate_low_supply_en, .gate_high_supply_en,
		.gate_high_discharge, .panel_digital_supply_en, .rectifier_limit,
		.high_side_switch_on, .low_side_switch_on, .inductor_current_limit);
	lsq_sys_model sys (.pclk, .presetn, .want_run, .want_en, .want_gates, .slow, .tie,
		.logic_switch_out, .logic_switch_oe_n, .run_pin, .en_pin, .gate_low_enable_pin,
		.gate_high_enable_pin, .logic_switch_in);
	always #2 pclk = ~pclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic tally_and_finish();
		$display("compared %0d, mismatched %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Slave answer time is unknown, so only the timeout bounds the wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic await(input int k, input logic v);
		@(negedge pclk);
		for (n = 1; n < 600 && obs[k] !== v; n++)
			@(negedge pclk);
		check(obs[k], v);
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, want_run, want_en} = '0;
		{want_gates, slow, tie, vin_above_rise, vin_above_fall, precharge_done} = '0;
		{source_good, gate_low_good, source_fault, gate_high_fault, gate_low_fault} = '0;
		{negative_feedback_level_thr, source_low, inductor_at_limit, inductor_empty} = '0;
		{req_boot, req_gate_high, req_gate_low} = '0;
		seed = 32'he0a65e23;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check(logic_switch_oe_n, 1'b1);
		check(inductor_current_limit, lsq_pkg::ILIM_START_MA);
		apb(1'b0, lsq_pkg::OFS_CTRL, 32'h0);
		check(rd, {30'h0, lsq_pkg::CTRL_RST});
		apb(1'b1, lsq_pkg::OFS_STATUS, 32'hffffffff);
		apb(1'b0, lsq_pkg::OFS_STATUS, 32'h0);
		check(rd, {16'h0, lsq_pkg::ILIM_START_MA, 8'h00});
		apb(1'b0, 8'h10, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
		repeat (4)
		begin
			seed = xs(seed);
			apb(1'b1, lsq_pkg::OFS_CTRL, seed);
			apb(1'b0, lsq_pkg::OFS_CTRL, 32'h0);
			check(rd, {30'h0, seed[1:0]});
		end
		apb(1'b1, lsq_pkg::OFS_CTRL, 32'h3);
		$display("done: registers");
		// Only the lower threshold seen: supply not yet valid
		@(posedge pclk);
		want_run <= 1'b1;
		vin_above_fall <= 1'b1;
		repeat (12) @(posedge pclk);
		@(negedge pclk);
		check(logic_switch_oe_n, 1'b1);
		check(reference_en, 1'b0);
		@(posedge pclk);
		vin_above_rise <= 1'b1;
		await(K_OE, 1'b0);
		check(logic_switch_out, 1'b0);
		check(rectifier_limit, 1'b1);
		check(boot_en, 1'b0);
		// Dropping under the upper threshold alone must not stop it
		@(posedge pclk);
		vin_above_rise <= 1'b0;
		precharge_done <= 1'b1;
		await(K_BOOT, 1'b1);
		check(rectifier_limit, 1'b0);
		for (n = 0; n < 600 && inductor_current_limit !== lsq_pkg::ILIM_FULL_MA; n++)
			@(negedge pclk);
		check(inductor_current_limit, lsq_pkg::ILIM_FULL_MA);
		check(n >= 85, 1'b1);
		$display("done: start-up");
		@(posedge pclk);
		want_en <= 1'b1;
		await(K_SRC, 1'b1);
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		check(gate_low_supply_en, 1'b0);
		@(posedge pclk);
		source_good <= 1'b1;
		await(K_GL, 1'b1);
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		check(gate_high_supply_en, 1'b0);
		@(posedge pclk);
		gate_low_good <= 1'b1;
		await(K_GH, 1'b1);
		$display("done: ordering");
		// Gate-low dumps through the low-side switch, others through high-side
		for (int t = 0; t < 3; t++)
		begin
			@(posedge pclk);
			{req_gate_low, req_gate_high, req_boot} <= 3'b100 >> t;
			inductor_empty <= 1'b0;
			await(K_BOTH, 1'b1);
			@(posedge pclk);
			inductor_at_limit <= 1'b1;
			await(K_BOTH, 1'b0);
			check(high_side_switch_on, t != 0);
			check(low_side_switch_on, t == 0);
			@(posedge pclk);
			{req_gate_low, req_gate_high, req_boot, inductor_at_limit} <= 4'h0;
			inductor_empty <= 1'b1;
			await((t == 0) ? K_LS : K_HS, 1'b0);
			check(high_side_switch_on | low_side_switch_on, 1'b0);
		end
		apb(1'b1, lsq_pkg::OFS_CTRL, 32'h2);
		await(K_BOTH, 1'b1);
		$display("done: switching");
		@(posedge pclk);
		want_run <= 1'b0;
		await(K_GH, 1'b0);
		check(gate_low_supply_en, 1'b0);
		@(negedge pclk);
		check(gate_high_discharge, 1'b1);
		repeat (6) @(posedge pclk);
		@(negedge pclk);
		check(source_drive_supply_en, 1'b1);
		@(posedge pclk);
		negative_feedback_level_thr <= 1'b1;
		await(K_SRC, 1'b0);
		check(panel_digital_supply_en, 1'b1);
		await(K_PAN, 1'b0);
		check(logic_switch_oe_n, 1'b1);
		@(posedge pclk);
		{want_en, negative_feedback_level_thr, source_good, gate_low_good} <= 4'h0;
		repeat (10) @(posedge pclk);
		$display("done: power-down");
		{want_run, want_en, source_good, gate_low_good} <= 4'hf;
		await(K_GH, 1'b1);
		// A fault shorter than the timer is ignored
		@(posedge pclk);
		source_fault <= 1'b1;
		repeat (10) @(posedge pclk);
		source_fault <= 1'b0;
		repeat (30) @(posedge pclk);
		@(negedge pclk);
		check(source_drive_supply_en, 1'b1);
		@(posedge pclk);
		gate_low_fault <= 1'b1;
		await(K_SRC, 1'b0);
		check(n inside {[20:28]}, 1'b1);
		check(gate_low_supply_en, 1'b0);
		check(gate_high_supply_en, 1'b0);
		@(posedge pclk);
		source_low <= 1'b1;
		await(K_OUT, 1'b1);
		check(logic_switch_oe_n, 1'b0);
		check(panel_digital_supply_en, 1'b0);
		@(posedge pclk);
		{gate_low_fault, source_low} <= 2'b00;
		repeat (20) @(posedge pclk);
		@(negedge pclk);
		check(source_drive_supply_en, 1'b0);
		// controller drops run and enable to clear the latch
		@(posedge pclk);
		{want_run, want_en} <= 2'b00;
		await(K_OE, 1'b1);
		apb(1'b0, lsq_pkg::OFS_STATUS, 32'h0);
		check(rd[6:4], 3'h0);
		$display("done: fault");
		// Tied run/enable with the switch pin held high: no ordering
		@(posedge pclk);
		tie <= 1'b1;
		repeat (8) @(posedge pclk);
		want_run <= 1'b1;
		await(K_SRC, 1'b1);
		check(logic_switch_oe_n, 1'b1);
		check(panel_digital_supply_en, 1'b0);
		@(posedge pclk);
		want_run <= 1'b0;
		await(K_SRC, 1'b0);
		check(gate_high_discharge, 1'b0);
		@(posedge pclk);
		tie <= 1'b0;
		repeat (8) @(posedge pclk);
		$display("done: bypass");
		@(posedge pclk);
		{want_run, slow} <= 2'b11;
		await(K_BOOT, 1'b1);
		@(posedge pclk);
		vin_above_fall <= 1'b0;
		await(K_REF, 1'b0);
		check(logic_switch_oe_n, 1'b1);
		check(boot_en, 1'b0);
		$display("done: lockout");
		tally_and_finish();
	end
endmodule // lsq_supply_ctrl_test
`default_nettype wire
